// *** rtl/dcr_defines.vh ***
// Constants for the DMA channel control register block.
// Assumes an 8-bit CPU I/O port with byte addresses.
`ifndef DCR_DEFINES_VH
`define DCR_DEFINES_VH
// Compatibility-mode port offsets, group 0-3.
`define DCR_LO_STATUS 8'h08
`define DCR_LO_MASK_BIT 8'h0a
`define DCR_LO_MODE 8'h0b
`define DCR_LO_CLR_PTR 8'h0c
`define DCR_LO_MCLR 8'h0d
`define DCR_LO_CLR_MASK 8'h0e
`define DCR_LO_MASK_ALL 8'h0f
// Compatibility-mode port offsets, group 4-7.
`define DCR_HI_STATUS 8'hd0
`define DCR_HI_MASK_BIT 8'hd4
`define DCR_HI_MODE 8'hd6
`define DCR_HI_CLR_PTR 8'hd8
`define DCR_HI_MCLR 8'hda
`define DCR_HI_CLR_MASK 8'hdc
`define DCR_HI_MASK_ALL 8'hde
// Extended-mode ports.
`define DCR_EXT_FUNC 8'h18
`define DCR_EXT_EXEC 8'h1a
// Extended commands, function register bits 7-4.
`define DCR_CMD_STATUS 4'h6
`define DCR_CMD_MODE 4'h7
`define DCR_CMD_ARB 4'h8
`define DCR_CMD_MASK_SET 4'h9
`define DCR_CMD_MASK_CLR 4'ha
`define DCR_CMD_MCLR 4'hd
// Field positions.
`define DCR_MASKBIT_POS 2
`define DCR_MODE_SEL_HI 7
`define DCR_MODE_SEL_LO 6
`define DCR_MODE_DIR_POS 5
`define DCR_MODE_AUTO_POS 4
`define DCR_MODE_TYPE_HI 3
`define DCR_MODE_TYPE_LO 2
// Reset values, the processor's arbitration level and the reserved transfer type.
`define DCR_MASK_RESET 4'hf
`define DCR_MODE_RESET 8'h00
`define DCR_ARB_RESET_0 4'h8
`define DCR_ARB_RESET_4 4'h9
`define DCR_ARB_SYSTEM 4'hf
`define DCR_XTYPE_RSVD 2'h3
`endif

// *** rtl/dcr_status_group.v ***
// One four-channel status byte: request and terminal count flags.
// Assumes request levels and terminal-count pulses are on i_clock.
`timescale 1ns/100ps
`default_nettype none
module dcr_status_group (
  // Clock and reset.
  input wire i_clock,
  input wire i_reset_n,
  // Events and clear.
  input wire i_clear,
  input wire [3:0] i_request,
  input wire [3:0] i_tc_pulse,
  // Status byte.
  output reg [7:0] o_status
);
  // Terminal count is sticky until read or cleared; a new pulse wins.
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_status <= 8'h00;
    end else begin
      o_status[7:4] <= i_clear ? 4'h0 : i_request;
      o_status[3:0] <= (i_clear ? 4'h0 : o_status[3:0]) | i_tc_pulse;
    end
  end
endmodule
`default_nettype wire

// *** rtl/dcr_regs.v ***
// Mask, mode, arbitration-level and status registers of an eight-channel DMA unit.
// Assumes the CPU I/O strobes are on i_clock, one-cycle wide, and only while idle.
`include "dcr_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module dcr_regs #(
  parameter CHANNELS = 8
) (
  // Clock and reset; transfers run on this same CPU clock.
  input wire i_clock,
  input wire i_reset_n,
  // CPU I/O port.
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  // Channel events from the transfer engine.
  input wire [CHANNELS-1:0] i_request,
  input wire [CHANNELS-1:0] i_tc_pulse,
  input wire i_timeout_clear,
  // Transfer data path through the holding register.
  input wire i_hold_load,
  input wire [15:0] i_hold_data,
  output reg [15:0] o_hold_data,
  // Channel configuration to the transfer engine.
  output wire [CHANNELS-1:0] o_enable,
  output wire [CHANNELS-1:0] o_demand_ok,
  output wire [CHANNELS-1:0] o_decrement,
  output wire [CHANNELS-1:0] o_autoinit,
  output wire [2*CHANNELS-1:0] o_xfer_type,
  output wire [3:0] o_arb_level_0,
  output wire [3:0] o_arb_level_4,
  output wire o_arb_warn_0,
  output wire o_arb_warn_4
);
  reg [3:0] mask_lo;
  reg [3:0] mask_hi;
  reg [7:0] mode [0:CHANNELS-1];
  reg [3:0] arb_0;
  reg [3:0] arb_4;
  reg [7:0] ext_func;
  reg byte_ptr;
  wire [7:0] status_lo;
  wire [7:0] status_hi;
  wire ext_cmd_wr;
  wire ext_exec_wr;
  wire ext_exec_rd;
  wire mclr;
  wire status_rd_lo;
  wire status_rd_hi;
  wire [3:0] cmd;
  wire [2:0] ext_ch;
  integer i;

  // Applies a single-bit set/reset write to a four-bit mask.
  function [3:0] mask_bit_update;
    input [3:0] cur;
    input [7:0] data;
    begin
      mask_bit_update = cur;
      mask_bit_update[data[1:0]] = data[`DCR_MASKBIT_POS];
    end
  endfunction

  // Codes 1-3 and 5-7 collide with fixed channels; F is the processor's.
  function level_warn;
    input [3:0] lvl;
    begin
      level_warn = (lvl[3] == 1'b0 && lvl[1:0] != 2'b00) || lvl == `DCR_ARB_SYSTEM;
    end
  endfunction

  assign cmd = ext_func[7:4];
  assign ext_ch = ext_func[2:0];
  assign ext_cmd_wr = i_wr && i_addr == `DCR_EXT_FUNC;
  assign ext_exec_wr = i_wr && i_addr == `DCR_EXT_EXEC;
  assign ext_exec_rd = i_rd && i_addr == `DCR_EXT_EXEC;
  assign mclr = i_timeout_clear ||
    (i_wr && (i_addr == `DCR_LO_MCLR || i_addr == `DCR_HI_MCLR)) ||
    (ext_cmd_wr && i_wdata[7:4] == `DCR_CMD_MCLR);
  // Compatibility reads clear only the half at their port; extended reads only the one shown.
  assign status_rd_lo = (i_rd && i_addr == `DCR_LO_STATUS) ||
    (ext_exec_rd && cmd == `DCR_CMD_STATUS && !byte_ptr);
  assign status_rd_hi = (i_rd && i_addr == `DCR_HI_STATUS) ||
    (ext_exec_rd && cmd == `DCR_CMD_STATUS && byte_ptr);

  // Mask registers, both access modes.
  always @(posedge i_clock) begin
    if (!i_reset_n || mclr) begin
      mask_lo <= `DCR_MASK_RESET;
      mask_hi <= `DCR_MASK_RESET;
    end else if (i_wr) begin
      case (i_addr)
        `DCR_LO_MASK_BIT: mask_lo <= mask_bit_update(mask_lo, i_wdata);
        `DCR_HI_MASK_BIT: mask_hi <= mask_bit_update(mask_hi, i_wdata);
        `DCR_LO_MASK_ALL: mask_lo <= i_wdata[3:0];
        `DCR_HI_MASK_ALL: mask_hi <= i_wdata[3:0];
        `DCR_LO_CLR_MASK: mask_lo <= 4'h0;
        `DCR_HI_CLR_MASK: mask_hi <= 4'h0;
        `DCR_EXT_FUNC: begin
          if (i_wdata[7:4] == `DCR_CMD_MASK_SET) begin
            mask_lo <= `DCR_MASK_RESET;
            mask_hi <= `DCR_MASK_RESET;
          end else if (i_wdata[7:4] == `DCR_CMD_MASK_CLR) begin
            mask_lo <= 4'h0;
            mask_hi <= 4'h0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Mode registers; both access modes store the same format.
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        mode[i] <= `DCR_MODE_RESET;
      end
    end else if (i_wr && i_addr == `DCR_LO_MODE) begin
      mode[{1'b0, i_wdata[1:0]}] <= i_wdata;
    end else if (i_wr && i_addr == `DCR_HI_MODE) begin
      mode[{1'b1, i_wdata[1:0]}] <= i_wdata;
    end else if (ext_exec_wr && cmd == `DCR_CMD_MODE) begin
      mode[ext_ch] <= {i_wdata[7:2], ext_ch[1:0]};
    end
  end

  // Arbitration levels; writes are live even mid-transfer.
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      arb_0 <= `DCR_ARB_RESET_0;
      arb_4 <= `DCR_ARB_RESET_4;
    end else if (ext_exec_wr && cmd == `DCR_CMD_ARB) begin
      if (ext_ch == 3'd0) begin
        arb_0 <= i_wdata[3:0];
      end else if (ext_ch == 3'd4) begin
        arb_4 <= i_wdata[3:0];
      end
    end
  end

  // Extended function register and byte pointer.
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      ext_func <= 8'h00;
      byte_ptr <= 1'b0;
    end else if (ext_cmd_wr) begin
      ext_func <= i_wdata;
      byte_ptr <= 1'b0;
    end else if (i_wr && (i_addr == `DCR_LO_CLR_PTR || i_addr == `DCR_HI_CLR_PTR)) begin
      byte_ptr <= 1'b0;
    end else if (ext_exec_rd || ext_exec_wr) begin
      byte_ptr <= ~byte_ptr;
    end
  end

  // Read data, registered one cycle after the strobe.
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      if (i_addr == `DCR_LO_STATUS) begin
        o_rdata <= status_lo;
      end else if (i_addr == `DCR_HI_STATUS) begin
        o_rdata <= status_hi;
      end else if (i_addr == `DCR_EXT_EXEC) begin
        case (cmd)
          `DCR_CMD_STATUS: o_rdata <= byte_ptr ? status_hi : status_lo;
          `DCR_CMD_MODE: o_rdata <= mode[ext_ch];
          `DCR_CMD_ARB: o_rdata <= {4'h0, (ext_ch[2] ? arb_4 : arb_0)};
          default: o_rdata <= 8'h00;
        endcase
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

  // Holding register, invisible to the CPU port.
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_hold_data <= 16'h0000;
    end else if (i_hold_load) begin
      o_hold_data <= i_hold_data;
    end
  end

  dcr_status_group u_status_lo (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_clear(mclr || status_rd_lo),
    .i_request(i_request[3:0]),
    .i_tc_pulse(i_tc_pulse[3:0]),
    .o_status(status_lo)
  );

  dcr_status_group u_status_hi (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_clear(mclr || status_rd_hi),
    .i_request(i_request[7:4]),
    .i_tc_pulse(i_tc_pulse[7:4]),
    .o_status(status_hi)
  );

  // Only demand mode runs; single, block and cascade are not honoured.
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_ch
      assign o_enable[g] = ~(g < 4 ? mask_lo[g % 4] : mask_hi[g % 4]) &&
        mode[g][`DCR_MODE_SEL_HI:`DCR_MODE_SEL_LO] == 2'b00 &&
        mode[g][`DCR_MODE_TYPE_HI:`DCR_MODE_TYPE_LO] != `DCR_XTYPE_RSVD;
      assign o_demand_ok[g] = mode[g][`DCR_MODE_SEL_HI:`DCR_MODE_SEL_LO] == 2'b00;
      assign o_decrement[g] = mode[g][`DCR_MODE_DIR_POS];
      assign o_autoinit[g] = mode[g][`DCR_MODE_AUTO_POS];
      assign o_xfer_type[2*g+1:2*g] = mode[g][`DCR_MODE_TYPE_HI:`DCR_MODE_TYPE_LO];
    end
  endgenerate

  assign o_arb_level_0 = arb_0;
  assign o_arb_level_4 = arb_4;
  assign o_arb_warn_0 = level_warn(arb_0);
  assign o_arb_warn_4 = level_warn(arb_4);
endmodule
`default_nettype wire

// *** sim/dcr_cpu_model.sv ***
// CPU local-bus master model for the register block's I/O port.
// Assumes the block samples its strobes on the rising edge of i_clock.
`timescale 1ns/100ps
`default_nettype none
module dcr_cpu_model (
  // Clock and read data.
  input wire logic i_clock,
  input wire logic [7:0] i_rdata,
  // I/O strobes.
  output var logic o_wr,
  output var logic o_rd,
  output var logic [7:0] o_addr,
  output var logic [7:0] o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'hff;
    o_wdata = 8'hff;
  end
  // Released lines show the inverse of their last value.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock) begin
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
    end
    @(posedge i_clock) begin
      o_wr <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
    end
    #1;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock) begin
      o_rd <= 1'b1;
      o_addr <= a;
    end
    @(posedge i_clock) begin
      o_rd <= 1'b0;
      o_addr <= ~a;
    end
    #1 d = i_rdata;
  endtask
endmodule
`default_nettype wire

// *** sim/dcr_regs_props.sv ***
// Checker for the DMA channel register block, watching its top ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module dcr_regs_props (
  // Watched ports.
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] i_request,
  input wire logic [7:0] i_tc_pulse,
  input wire logic i_timeout_clear,
  input wire logic [7:0] o_enable,
  input wire logic [7:0] o_demand_ok,
  input wire logic [7:0] o_decrement,
  input wire logic [3:0] o_arb_level_0,
  input wire logic [3:0] o_arb_level_4,
  input wire logic o_arb_warn_4
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  a_master_clear: assert property ((i_timeout_clear || i_wr && i_addr == 8'h0d)
    |=> o_enable[3:0] == 4'h0) else $error("mask not set by clear");
  a_mask_bit_set: assert property (i_wr && i_addr == 8'h0a && i_wdata[2]
    |=> !o_enable[$past(i_wdata[1:0])]) else $error("single mask bit ignored");
  a_mode_dir: assert property (i_wr && i_addr == 8'h0b
    |=> o_decrement[$past(i_wdata[1:0])] == $past(i_wdata[5])) else $error("mode direction");
  a_demand_only: assert property ((o_enable & ~o_demand_ok) == 8'h00)
    else $error("non-demand channel enabled");
  a_level_stable: assert property (!i_wr && !i_timeout_clear
    |=> $stable({o_arb_level_0, o_arb_level_4})) else $error("level changed without write");
  a_level_warn: assert property (o_arb_warn_4 ==
    (o_arb_level_4 inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'hf})) else $error("warn flag");
  a_unmapped_read: assert property (i_rd && i_addr == 8'h40 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!i_rd |=> $stable(o_rdata)) else $error("read data moved");
  a_tc_report: assert property (i_tc_pulse[1] ##1 !i_rd && !i_wr && !i_timeout_clear
    ##1 i_rd && i_addr == 8'h08 |=> o_rdata[1]) else $error("terminal count lost");
  a_req_report: assert property (i_request[5] ##1 i_request[5] && i_rd && i_addr == 8'hd0
    |=> o_rdata[5]) else $error("request not reported");
  c_ext_exec: cover property (i_rd && i_addr == 8'h1a);
  c_mclr: cover property (i_wr && i_addr == 8'h0d);
  c_warn: cover property (o_arb_warn_4);
endmodule
bind dcr_regs dcr_regs_props u_props (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_wr(i_wr),
  .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_request(i_request),
  .i_tc_pulse(i_tc_pulse), .i_timeout_clear(i_timeout_clear), .o_enable(o_enable),
  .o_demand_ok(o_demand_ok), .o_decrement(o_decrement), .o_arb_level_0(o_arb_level_0),
  .o_arb_level_4(o_arb_level_4), .o_arb_warn_4(o_arb_warn_4));
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the DMA channel register block.
// Assumes a CPU model on the I/O port and bench-driven channel events.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic i_clock = 1'b0, i_reset_n = 1'b0, wr, rd, i_timeout_clear = 1'b0, i_hold_load = 1'b0;
  logic w4, w0;
  logic [7:0] addr, wdata, rdata, i_request = 8'h00, i_tc_pulse = 8'h00, en, dok, dec, aut, d;
  logic [15:0] xt, i_hold_data = 16'h0000, hold;
  logic [3:0] a0, a4;
  int miscompares = 0, n_compared = 0, cycles = 0;
  dcr_cpu_model cpu (.i_clock(i_clock), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata));
  dcr_regs dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wdata), .o_rdata(rdata), .i_request(i_request), .i_tc_pulse(i_tc_pulse),
    .i_timeout_clear(i_timeout_clear), .i_hold_load(i_hold_load), .i_hold_data(i_hold_data),
    .o_hold_data(hold), .o_enable(en), .o_demand_ok(dok), .o_decrement(dec), .o_autoinit(aut),
    .o_xfer_type(xt), .o_arb_level_0(a0), .o_arb_level_4(a4), .o_arb_warn_0(w0),
    .o_arb_warn_4(w4));
  initial forever #20 i_clock = ~i_clock;
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task close_out;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      close_out;
    end
  end
  task t_reset;
    chk("enable", 8'h00, en);
    chk("levels", 8'h89, {a0, a4});
    cpu.rd(8'h08, d);
    chk("status", 8'h00, d);
    $display("reset test done");
  endtask
  task t_mode_mask;
    cpu.wr(8'h0b, 8'h16);
    cpu.wr(8'h0e, 8'h00);
    chk("mode ch2", 4'h6, {xt[5:4], aut[2], dec[2]});
    chk("enable lo", 4'hf, en[3:0]);
    cpu.wr(8'h0a, 8'h06);
    chk("mask bit", 4'hb, en[3:0]);
    cpu.wr(8'h0f, 8'h05);
    chk("mask all", 4'ha, en[3:0]);
    cpu.wr(8'hd6, 8'h4f);
    cpu.wr(8'hdc, 8'h00);
    chk("single unused", 4'h7, en[7:4]);
    cpu.wr(8'hd6, 8'h2b);
    chk("ch7 demand", 2'h3, {en[7], dec[7]});
    cpu.wr(8'h18, 8'h71);
    cpu.wr(8'h1a, 8'h08);
    chk("ext mode", 2'h2, xt[3:2]);
    cpu.wr(8'h0d, 8'h00);
    chk("mclr all", 8'h00, en);
    cpu.wr(8'h0e, 8'h00);
    cpu.wr(8'hdc, 8'h00);
    chk("unmask all", 8'hff, en);
    @(posedge i_clock) i_timeout_clear <= 1'b1;
    @(posedge i_clock) i_timeout_clear <= 1'b0;
    #1 chk("timeout clear", 8'h00, en);
    $display("mode and mask test done");
  endtask
  task t_arb;
    @(posedge i_clock) i_request <= 8'h21;
    cpu.wr(8'h18, 8'h80); // Level 0c is an unshared level
    cpu.wr(8'h1a, 8'h0c);
    chk("level 0", 5'h18, {a0, w0});
    cpu.wr(8'h18, 8'h84); // Level 05 is shared on purpose, so the warn flag sets
    cpu.wr(8'h1a, 8'h05);
    chk("level 4", 5'h0b, {a4, w4});
    cpu.wr(8'h18, 8'h81);
    cpu.wr(8'h1a, 8'h03);
    chk("level ch1", 4'hc, a0);
    $display("arbitration test done");
  endtask
  task t_status;
    @(posedge i_clock) i_tc_pulse <= 8'h42;
    @(posedge i_clock) i_tc_pulse <= 8'h00;
    cpu.rd(8'h08, d);
    chk("status lo", 8'h12, d);
    cpu.wr(8'h18, 8'h60);
    cpu.rd(8'h1a, d);
    chk("ext lo", 8'h10, d);
    cpu.rd(8'h1a, d);
    chk("ext hi", 8'h24, d);
    cpu.wr(8'h18, 8'h60);
    cpu.rd(8'h1a, d);
    chk("ptr reset", 8'h10, d);
    cpu.rd(8'h40, d);
    chk("unmapped", 8'h00, d);
    cpu.rd(8'hd0, d);
    chk("status hi", 8'h20, d);
    $display("status test done");
  endtask
  task t_hold;
    @(posedge i_clock) begin
      i_hold_load <= 1'b1;
      i_hold_data <= 16'h5a3c;
    end
    @(posedge i_clock) i_hold_load <= 1'b0;
    #1 chk("hold", 16'h5a3c, hold);
    $display("hold test done");
  endtask
  initial begin
    repeat (20) @(posedge i_clock);
    i_reset_n <= 1'b1;
    t_reset;
    t_mode_mask;
    t_arb;
    t_status;
    t_hold;
    close_out;
  end
endmodule
`default_nettype wire
